// ==== io_bank_pkg.sv ====
// Package holding register offsets, port indices and reset values of the I/O port bank.
package io_bank_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    // Each port takes a four-word slot: setup, output value, pin levels, one unused word.
    localparam logic [7:0] port_stride = 8'h10;
    localparam logic [7:0] setup_offset = 8'h00;
    localparam logic [7:0] value_offset = 8'h04;
    localparam logic [7:0] levels_offset = 8'h08;
    // Option register holding the fuse-like options of the bank.
    localparam logic [7:0] option_offset = 8'h40;
    // Status register showing the low-power request state.
    localparam logic [7:0] power_offset = 8'h44;

    // ----------------------------------------
    // Port indices
    // ----------------------------------------
    localparam int port_count = 4;
    localparam logic [1:0] port_wake = 2'h0;
    localparam logic [1:0] port_system = 2'h1;
    localparam logic [1:0] port_cmp = 2'h2;
    localparam logic [1:0] port_aux = 2'h3;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int sys_alarm_bit = 1;
    localparam int sys_idle_bit = 6;
    localparam int sys_halt_bit = 7;
    localparam int opt_supervisor_bit = 0;
    localparam int opt_clk_lsb = 1;
    localparam int pwr_halt_bit = 0;
    localparam int pwr_idle_bit = 1;

    // ----------------------------------------
    // Clock options and reset values
    // ----------------------------------------
    localparam logic [1:0] clk_crystal = 2'h0;
    localparam logic [1:0] clk_rc = 2'h1;
    localparam logic [1:0] clk_external = 2'h2;
    localparam logic [7:0] reg_reset = 8'h00;
    localparam logic [2:0] option_reset = 3'h0;

endpackage

// ==== pin_cell.sv ====
// Single pin cell deciding drive, enable and weak pull-up from setup and value bits.
`timescale 1ns/1ps
`default_nettype none

module pin_cell (
    input wire logic setup_bit,
    input wire logic value_bit,
    output logic drive_out,
    output logic drive_oe,
    output logic pull_up
);

    // Setup selects drive, value selects level or pull-up when not driving.
    always_comb begin
        drive_oe = setup_bit;
        drive_out = value_bit;
        pull_up = !setup_bit && value_bit;
    end

endmodule

`default_nettype wire

// ==== io_port_bank.sv ====
// Four-port bidirectional I/O bank with APB register access.
`timescale 1ns/1ps
`default_nettype none

module io_port_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe,
    output logic [31:0] pin_pull_up,
    input wire logic crystal_clock,
    input wire logic supervisor_alarm,
    input wire logic wake_ack,
    output logic halt_req,
    output logic idle_req,
    output logic alt_serial_phase,
    output logic restart_delay_enable,
    output logic halt_wake,
    output logic [7:0] wakeup_sources,
    output logic [3:0] timer_pins_23,
    output logic [2:0] uart_pins,
    output logic [5:0] comparator_pins,
    output logic [5:0] system_alt_pins
);

    // ----------------------------------------
    // Registers and decode
    // ----------------------------------------
    logic [7:0] setup_r [io_bank_pkg::port_count];
    logic [7:0] value_r [io_bank_pkg::port_count];
    logic [2:0] option_r;
    logic [31:0] sync1_r;
    logic [31:0] sync2_r;
    logic g7_prev_r;
    logic [31:0] pin_out_nxt;
    logic [31:0] pin_oe_nxt;
    logic [31:0] pin_pull_nxt;
    logic access;
    logic [1:0] sel_port;
    logic [7:0] sel_off;
    logic in_ports;
    logic supervisor_on;
    logic crystal_mode;
    logic g7_level;

    // Returns true when the address hits a valid word of the map.
    function automatic logic addr_mapped(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        if (a < io_bank_pkg::option_offset) begin
            hit = (a[3:0] == io_bank_pkg::setup_offset[3:0]) ||
                  (a[3:0] == io_bank_pkg::value_offset[3:0]) ||
                  (a[3:0] == io_bank_pkg::levels_offset[3:0]);
        end else begin
            hit = (a == io_bank_pkg::option_offset) || (a == io_bank_pkg::power_offset);
        end
        return hit;
    endfunction

    assign access = psel && penable;
    assign sel_port = paddr[5:4];
    assign sel_off = {4'h0, paddr[3:0]};
    assign in_ports = paddr < io_bank_pkg::option_offset;
    assign supervisor_on = option_r[io_bank_pkg::opt_supervisor_bit];
    assign crystal_mode = option_r[io_bank_pkg::opt_clk_lsb +: 2] == io_bank_pkg::clk_crystal;
    assign g7_level = sync2_r[8 + io_bank_pkg::sys_halt_bit];

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Setup and value registers per port, written on the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < io_bank_pkg::port_count; i++) begin
                setup_r[i] <= io_bank_pkg::reg_reset;
                value_r[i] <= io_bank_pkg::reg_reset;
            end
        end else if (access && pwrite && in_ports) begin
            if (sel_off == io_bank_pkg::setup_offset) begin
                setup_r[sel_port] <= pwdata[7:0];
            end else if (sel_off == io_bank_pkg::value_offset) begin
                value_r[sel_port] <= pwdata[7:0];
            end
        end
    end

    // Option register: supervisor enable and clock option.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option_r <= io_bank_pkg::option_reset;
        end else if (access && pwrite && paddr == io_bank_pkg::option_offset) begin
            option_r <= pwdata[2:0];
        end
    end

    // ----------------------------------------
    // Low-power requests
    // ----------------------------------------
    // A one written to value bit 7 or 6 raises halt or idle; idle stands until the power
    // controller acknowledges a wake, halt until that or, outside crystal mode, a wake edge on the bit 7 pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_req <= 1'b0;
            idle_req <= 1'b0;
        end else begin
            if (access && pwrite && paddr == io_bank_pkg::port_stride + io_bank_pkg::value_offset
                && pwdata[io_bank_pkg::sys_halt_bit]) begin
                halt_req <= 1'b1;
            end else if (wake_ack || halt_wake) begin
                halt_req <= 1'b0;
            end
            if (access && pwrite && paddr == io_bank_pkg::port_stride + io_bank_pkg::value_offset
                && pwdata[io_bank_pkg::sys_idle_bit]) begin
                idle_req <= 1'b1;
            end else if (wake_ack) begin
                idle_req <= 1'b0;
            end
        end
    end

    // Serial phase follows system setup bit 6; restart delay follows setup bit 7 under the R/C clock option only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_serial_phase <= 1'b0;
            restart_delay_enable <= 1'b0;
        end else begin
            alt_serial_phase <= setup_r[io_bank_pkg::port_system][io_bank_pkg::sys_idle_bit];
            restart_delay_enable <= setup_r[io_bank_pkg::port_system][io_bank_pkg::sys_halt_bit]
                && option_r[io_bank_pkg::opt_clk_lsb +: 2] == io_bank_pkg::clk_rc;
        end
    end

    // ----------------------------------------
    // Pin synchroniser and wake detect
    // ----------------------------------------
    // Two stages guard against metastable pin levels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 32'h0000_0000;
            sync2_r <= 32'h0000_0000;
            g7_prev_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            g7_prev_r <= g7_level;
        end
    end

    // Rising edge on the system bit 7 pin ends halt outside crystal mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_wake <= 1'b0;
        end else begin
            halt_wake <= !crystal_mode && halt_req && g7_level && !g7_prev_r;
        end
    end

    // ----------------------------------------
    // Pin cells
    // ----------------------------------------
    genvar gp, gb;
    generate
        for (gp = 0; gp < io_bank_pkg::port_count; gp++) begin : g_port
            for (gb = 0; gb < 8; gb++) begin : g_bit
                pin_cell u_cell (
                    .setup_bit(setup_r[gp][gb]),
                    .value_bit(value_r[gp][gb]),
                    .drive_out(pin_out_nxt[gp*8+gb]),
                    .drive_oe(pin_oe_nxt[gp*8+gb]),
                    .pull_up(pin_pull_nxt[gp*8+gb])
                );
            end
        end
    endgenerate

    // Pin drivers with the system port overrides applied on top.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 32'h0000_0000;
            pin_oe <= 32'h0000_0000;
            pin_pull_up <= 32'h0000_0000;
        end else begin
            pin_out <= pin_out_nxt;
            pin_oe <= pin_oe_nxt;
            pin_pull_up <= pin_pull_nxt;
            if (supervisor_on) begin
                pin_out[8 + io_bank_pkg::sys_alarm_bit] <= 1'b0;
                // The pin is pulled low only while the alarm stands, else the pull-up holds it.
                pin_oe[8 + io_bank_pkg::sys_alarm_bit] <= supervisor_alarm;
                pin_pull_up[8 + io_bank_pkg::sys_alarm_bit] <= 1'b1;
            end
            pin_out[8 + io_bank_pkg::sys_idle_bit] <= 1'b0;
            pin_oe[8 + io_bank_pkg::sys_idle_bit] <= 1'b0;
            pin_pull_up[8 + io_bank_pkg::sys_idle_bit] <= 1'b0;
            pin_out[8 + io_bank_pkg::sys_halt_bit] <= crystal_mode && crystal_clock;
            pin_oe[8 + io_bank_pkg::sys_halt_bit] <= crystal_mode;
            pin_pull_up[8 + io_bank_pkg::sys_halt_bit] <= 1'b0;
        end
    end

    // ----------------------------------------
    // Alternate function taps
    // ----------------------------------------
    // Synchronised pin levels are handed to the peripherals.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wakeup_sources <= 8'h00;
            timer_pins_23 <= 4'h0;
            uart_pins <= 3'h0;
            comparator_pins <= 6'h00;
            system_alt_pins <= 6'h00;
        end else begin
            wakeup_sources <= sync2_r[7:0];
            timer_pins_23 <= sync2_r[7:4];
            uart_pins <= sync2_r[3:1];
            comparator_pins <= sync2_r[22:17];
            system_alt_pins <= {sync2_r[14:12], sync2_r[11:10], sync2_r[8]};
        end
    end

    // ----------------------------------------
    // APB read path
    // ----------------------------------------
    // Read data and error are registered in the setup cycle so that the
    // access phase completes with zero wait states.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_mapped(paddr);
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                if (in_ports && sel_off == io_bank_pkg::setup_offset) begin
                    prdata <= {24'h00_0000, setup_r[sel_port]};
                end else if (in_ports && sel_off == io_bank_pkg::value_offset) begin
                    prdata <= {24'h00_0000, value_r[sel_port]};
                    if (sel_port == io_bank_pkg::port_system) begin
                        prdata <= {24'h00_0000, 2'b00, value_r[sel_port][5:0]};
                    end
                end else if (in_ports && sel_off == io_bank_pkg::levels_offset) begin
                    // Unbonded pins are read as whatever the input shows.
                    prdata <= {24'h00_0000, sync2_r[sel_port*8 +: 8]};
                end else if (paddr == io_bank_pkg::option_offset) begin
                    prdata <= {29'h0000_0000, option_r};
                end else if (paddr == io_bank_pkg::power_offset) begin
                    prdata <= {30'h0000_0000, idle_req, halt_req};
                end
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_halt_write;
        access && pwrite && paddr == io_bank_pkg::port_stride + io_bank_pkg::value_offset
            && pwdata[io_bank_pkg::sys_halt_bit];
    endsequence

    property p_halt_entry;
        @(posedge pclk) disable iff (!presetn) s_halt_write |=> halt_req;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt not requested");

    property p_idle_entry;
        @(posedge pclk) disable iff (!presetn)
            access && pwrite && paddr == io_bank_pkg::port_stride + io_bank_pkg::value_offset
            && pwdata[io_bank_pkg::sys_idle_bit] |=> idle_req;
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle not requested");

    property p_g6_input;
        @(posedge pclk) disable iff (!presetn) ##1 !pin_oe[14] && !pin_pull_up[14];
    endproperty
    a_g6_input: assert property (p_g6_input) else $error("bit 6 pin driven");

    property p_sys_read_zero;
        @(posedge pclk) disable iff (!presetn)
            psel && !penable && !pwrite && paddr == 8'h14 |=> prdata[7:6] == 2'b00;
    endproperty
    a_sys_read_zero: assert property (p_sys_read_zero) else $error("value bits 6-7 nonzero");

    property p_push_pull;
        @(posedge pclk) disable iff (!presetn)
            setup_r[0][0] && value_r[0][0] |=> pin_oe[0] && pin_out[0];
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull one wrong");

    property p_pull_up;
        @(posedge pclk) disable iff (!presetn)
            !setup_r[0][0] && value_r[0][0] |=> !pin_oe[0] && pin_pull_up[0];
    endproperty
    a_pull_up: assert property (p_pull_up) else $error("pull-up input wrong");

    property p_alarm_override;
        @(posedge pclk) disable iff (!presetn) supervisor_on |=> pin_pull_up[9];
    endproperty
    a_alarm_override: assert property (p_alarm_override) else $error("alarm pin no pull-up");

    property p_sync_delay;
        @(posedge pclk) disable iff (!presetn) $past(presetn, 2) |-> sync2_r == $past(pin_in, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync not two stages");

    property p_serial_phase;
        @(posedge pclk) disable iff (!presetn)
            setup_r[1][6] |=> alt_serial_phase;
    endproperty
    a_serial_phase: assert property (p_serial_phase) else $error("serial phase not set");

endmodule

`default_nettype wire

// ==== pin_world.sv ====
// External circuit model that resolves the level of every pin of the bank.
`timescale 1ns/1ps
`default_nettype none

module pin_world (
    input wire logic pclk,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pin_pull_up,
    input wire logic [31:0] ext_val,
    input wire logic [31:0] ext_oe,
    output logic [31:0] pin_level
);
    logic [31:0] float_r = 32'h0000_0000;

    // A floating line changes every cycle, so a stale level never passes for a driven one.
    always @(posedge pclk) begin
        float_r <= ~float_r;
    end

    // Device drive first, then outside drive, then the weak pull-up, else floating.
    always_comb begin
        pin_level = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val);
        pin_level = pin_level | (~pin_oe & ~ext_oe & (pin_pull_up | (~pin_pull_up & float_r)));
    end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking testbench of the four-port I/O bank.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, pin_in, pin_out, pin_oe, pin_pull_up, ext_val, ext_oe, rd;
    logic crystal_clock, supervisor_alarm, wake_ack, er;
    logic halt_req, idle_req, alt_serial_phase, restart_delay_enable, halt_wake;
    logic [7:0] wakeup_sources;
    logic [3:0] timer_pins_23;
    logic [5:0] comparator_pins;
    logic [2:0] uart_pins;
    logic [5:0] system_alt_pins;
    int err_total = 0;
    int n_checks = 0;
    int wake_cnt = 0;
    int c0;
    int pl [3] = '{0, 2, 3};
    // Rows: setup, value, expected enable, expected drive, expected pull-up.
    logic [7:0] rows [4][5] = '{'{8'h0F, 8'h33, 8'h0F, 8'h03, 8'h30},
        '{8'hF0, 8'h55, 8'hF0, 8'h50, 8'h05}, '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00},
        '{8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF}};

    io_port_bank io_port_bank_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pull_up(pin_pull_up), .crystal_clock(crystal_clock),
        .supervisor_alarm(supervisor_alarm), .wake_ack(wake_ack), .halt_req(halt_req),
        .idle_req(idle_req), .alt_serial_phase(alt_serial_phase),
        .restart_delay_enable(restart_delay_enable), .halt_wake(halt_wake),
        .wakeup_sources(wakeup_sources), .timer_pins_23(timer_pins_23), .uart_pins(uart_pins),
        .comparator_pins(comparator_pins), .system_alt_pins(system_alt_pins));

    pin_world pin_world_i (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull_up(pin_pull_up), .ext_val(ext_val), .ext_oe(ext_oe), .pin_level(pin_in));

    // Clock of 20 ns period.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Counts wake pulses from the clock-pin input.
    always @(posedge pclk) begin
        if (halt_wake === 1'b1) begin
            wake_cnt++;
        end
    end

    task finish_test;
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
        n_checks++;
        if ((got & msk) !== (exp & msk)) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h mask %h", $time, got, exp, msk);
        end
    endtask

    // One APB transfer; read data and error are taken at the edge that samples pready.
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
        apb(a, 1'b0, 32'h0000_0000);
        chk(rd, exp, msk);
    endtask

    // Register write, one cycle to the pins, two sync stages and one copy stage.
    task settle;
        repeat (4) @(posedge pclk);
    endtask

    function automatic logic [7:0] ad(input int p, input logic [7:0] off);
        return 8'(p * io_bank_pkg::port_stride) + off;
    endfunction

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, crystal_clock, supervisor_alarm, wake_ack} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        ext_val = 32'h0000_0000;
        ext_oe = 32'h0000_0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk(pin_oe, 32'h0000_0000, 32'hFFFF_FFFF);
        for (int p = 0; p < 4; p++) begin
            rd_chk(ad(p, io_bank_pkg::setup_offset), {24'h0, io_bank_pkg::reg_reset}, '1);
            rd_chk(ad(p, io_bank_pkg::value_offset), {24'h0, io_bank_pkg::reg_reset}, '1);
        end
        // Ordinary ports through every setup and value combination.
        foreach (pl[i]) begin
            for (int r = 0; r < 4; r++) begin
                apb(ad(pl[i], io_bank_pkg::setup_offset), 1'b1, {24'h0, rows[r][0]});
                apb(ad(pl[i], io_bank_pkg::value_offset), 1'b1, {24'h0, rows[r][1]});
                settle();
                chk(pin_oe >> (8 * pl[i]), {24'h0, rows[r][2]}, 32'h0000_00FF);
                chk(pin_out >> (8 * pl[i]), {24'h0, rows[r][3]}, {24'h0, rows[r][2]});
                chk(pin_pull_up >> (8 * pl[i]), {24'h0, rows[r][4]}, 32'h0000_00FF);
                rd_chk(ad(pl[i], io_bank_pkg::setup_offset), {24'h0, rows[r][0]}, '1);
                rd_chk(ad(pl[i], io_bank_pkg::value_offset), {24'h0, rows[r][1]}, '1);
                rd_chk(ad(pl[i], io_bank_pkg::levels_offset), {24'h0, rows[r][3] | rows[r][4]},
                    {24'h0, rows[r][2] | rows[r][4]});
            end
        end
        apb(8'h4C, 1'b1, 32'h0000_00FF);
        chk({31'h0, er}, 32'h0000_0001, '1);
        rd_chk(8'h4C, 32'h0000_0000, '1);
        // System port under the crystal option with every bit set up as driven, bits 0 to 5 high.
        apb(ad(1, io_bank_pkg::setup_offset), 1'b1, 32'h0000_00FF);
        apb(ad(1, io_bank_pkg::value_offset), 1'b1, 32'h0000_003F);
        settle();
        chk(pin_oe, 32'h0000_8200, 32'h0000_C200);
        chk(pin_pull_up, 32'h0000_0000, 32'h0000_4000);
        chk(pin_out, 32'h0000_0200, 32'h0000_8200);
        chk({30'h0, alt_serial_phase, restart_delay_enable}, 32'h0000_0002, '1);
        crystal_clock <= 1'b1;
        settle();
        chk(pin_out, 32'h0000_8000, 32'h0000_8000);
        // Supervisor on, internal R/C clock.
        apb(io_bank_pkg::option_offset, 1'b1, 32'h0000_0003);
        settle();
        chk(pin_oe, 32'h0000_0000, 32'h0000_8200);
        chk(pin_pull_up, 32'h0000_0200, 32'h0000_0200);
        chk({31'h0, restart_delay_enable}, 32'h0000_0001, '1);
        supervisor_alarm <= 1'b1;
        settle();
        chk(pin_oe, 32'h0000_0200, 32'h0000_0200);
        chk(pin_out, 32'h0000_0000, 32'h0000_0200);
        supervisor_alarm <= 1'b0;
        // Low-power requests, read-back and release.
        ext_oe <= 32'h0000_8000;
        apb(ad(1, io_bank_pkg::value_offset), 1'b1, 32'h0000_00FF);
        settle();
        chk({30'h0, halt_req, idle_req}, 32'h0000_0003, '1);
        rd_chk(ad(1, io_bank_pkg::value_offset), 32'h0000_003F, '1);
        rd_chk(io_bank_pkg::power_offset, 32'h0000_0003, '1);
        wake_ack <= 1'b1;
        @(posedge pclk);
        wake_ack <= 1'b0;
        settle();
        chk({30'h0, halt_req, idle_req}, 32'h0000_0000, '1);
        // Halt left by a rising edge on the clock pin.
        apb(ad(1, io_bank_pkg::value_offset), 1'b1, 32'h0000_0080);
        settle();
        chk({30'h0, halt_req, idle_req}, 32'h0000_0002, '1);
        c0 = wake_cnt;
        ext_val <= 32'h0000_8000;
        settle();
        // One more edge so the pulse counter and the cleared request have settled.
        @(posedge pclk);
        chk(wake_cnt - c0, 32'h0000_0001, '1);
        chk({31'h0, halt_req}, 32'h0000_0000, '1);
        // Outside levels reach the wakeup, timer and comparator inputs.
        apb(ad(0, io_bank_pkg::value_offset), 1'b1, 32'h0000_0000);
        apb(ad(2, io_bank_pkg::value_offset), 1'b1, 32'h0000_0000);
        apb(ad(1, io_bank_pkg::setup_offset), 1'b1, 32'h0000_0000);
        apb(ad(1, io_bank_pkg::value_offset), 1'b1, 32'h0000_0000);
        ext_oe <= 32'h00FF_7DFF;
        ext_val <= 32'h005A_5DA5;
        settle();
        chk({29'h0, uart_pins}, 32'h0000_0002, '1);
        chk({26'h0, system_alt_pins}, 32'h0000_002F, '1);
        chk({24'h0, wakeup_sources}, 32'h0000_00A5, '1);
        chk({28'h0, timer_pins_23}, 32'h0000_000A, '1);
        chk({26'h0, comparator_pins}, 32'h0000_002D, '1);
        rd_chk(ad(0, io_bank_pkg::levels_offset), 32'h0000_00A5, '1);
        finish_test();
    end

    // Cuts a hang short well beyond the length of the whole sequence.
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
